// ---- shared/twp_pkg.sv ----
// package: offsets, fields, reset values and the key of the write-protect unit
package twp_pkg;
    // register byte offsets
    localparam logic [11:0] OFF_FIFO_MODE   = 12'h650;
    localparam logic [11:0] OFF_FIFO_IEN    = 12'h664;
    localparam logic [11:0] OFF_FIFO_IDIS   = 12'h668;
    localparam logic [11:0] OFF_FIFO_IMASK  = 12'h66c;
    localparam logic [11:0] OFF_CTRL        = 12'h600;
    localparam logic [11:0] OFF_PROT_MODE   = 12'h6e4;
    localparam logic [11:0] OFF_PROT_STAT   = 12'h6e8;
    localparam logic [11:0] OFF_IRQ_STAT    = 12'h6f0;
    localparam logic [11:0] OFF_IRQ_MASK    = 12'h6f4;
    localparam logic [11:0] OFF_SYS_OPT     = 12'h6f8;
    // key field and lock bit positions
    localparam logic [23:0] KEY_ACCEPT_VALUE = 24'h545749;
    localparam int          KEY_LSB          = 8;
    localparam int          BIT_GENERAL      = 0;
    localparam int          BIT_IRQ_REGS     = 1;
    localparam int          BIT_CTRL_REG     = 2;
    localparam int          BIT_VIOL         = 0;
    localparam int          SRC_LSB          = 8;
    // reset values
    localparam logic [2:0]  PROT_MODE_RST    = 3'h0;
    localparam logic [31:0] WORD_RST         = 32'h00000000;
    // fifo mode writable fields
    localparam logic [31:0] FIFO_MODE_MASK   = 32'h3f3f0033;
    localparam logic [7:0]  FIFO_IRQ_RST     = 8'h00;
    // interrupt event bits
    localparam int          EV_VIOL          = 0;
    localparam int          EV_KEY_FAIL      = 1;
    localparam int          NUM_EV           = 2;
    // bus slave states
    typedef enum logic [1:0] {
        TWP_IDLE  = 2'b00,
        TWP_WRITE = 2'b01,
        TWP_READ  = 2'b11
    } twp_state_t;
endpackage

// ---- shared/twp_wr_if.sv ----
// interface: one decoded register write carried from the bus slave to the guard
`timescale 1ns/1ps
`default_nettype none
interface twp_wr_if;
    logic        wr_en;
    logic [11:0] wr_off;
    logic [31:0] wr_data;
    logic        allow;
    logic        reject;
    modport src (output wr_en, output wr_off, output wr_data, input allow, input reject);
    modport chk (input wr_en, input wr_off, input wr_data, output allow, output reject);
endinterface
`default_nettype wire

// ---- logic/twp_guard.sv ----
// write guard: decides whether a write to a lockable register may proceed
`timescale 1ns/1ps
`default_nettype none
module twp_guard
    import twp_pkg::*;
(
    twp_wr_if.chk        wr,
    input  wire logic [2:0] locks
);
    // which lock group the offset belongs to
    wire hit_general = (wr.wr_off == OFF_FIFO_MODE);
    wire hit_irq     = (wr.wr_off == OFF_FIFO_IEN) || (wr.wr_off == OFF_FIFO_IDIS);
    wire hit_ctrl    = (wr.wr_off == OFF_CTRL);
    wire blocked     = (hit_general && locks[BIT_GENERAL])
                     || (hit_irq && locks[BIT_IRQ_REGS])
                     || (hit_ctrl && locks[BIT_CTRL_REG]);
    // rejected writes are silent on the bus, only reported
    assign wr.reject = wr.wr_en && blocked;
    assign wr.allow  = wr.wr_en && !blocked;
endmodule
`default_nettype wire

// ---- logic/twp_ctrl_store.sv ----
// store for the guarded fifo-mode, fifo interrupt mask and control words
`timescale 1ns/1ps
`default_nettype none
module twp_ctrl_store
    import twp_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        we,
    input  wire logic [11:0] off,
    input  wire logic [31:0] wdata,
    input  wire logic [11:0] roff,
    output logic      [31:0] rdata
);
    logic [31:0] fifo_mode_q;
    logic [7:0]  fifo_imask_q;
    logic [31:0] ctrl_q;
    wire  [31:0] rd_d = (roff == OFF_FIFO_MODE)  ? fifo_mode_q :
                        (roff == OFF_FIFO_IMASK) ? {24'h000000, fifo_imask_q} :
                        (roff == OFF_CTRL)       ? ctrl_q : WORD_RST;
    // writes reach here only once the guard allowed them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_mode_q  <= WORD_RST;
            fifo_imask_q <= FIFO_IRQ_RST;
            ctrl_q       <= WORD_RST;
            rdata        <= WORD_RST;
        end else begin
            rdata <= rd_d;
            if (we && off == OFF_FIFO_MODE)
                fifo_mode_q <= wdata & FIFO_MODE_MASK;
            if (we && off == OFF_FIFO_IEN)
                fifo_imask_q <= fifo_imask_q | wdata[7:0];
            if (we && off == OFF_FIFO_IDIS)
                fifo_imask_q <= fifo_imask_q & ~wdata[7:0];
            if (we && off == OFF_CTRL)
                ctrl_q <= wdata;
        end
    end
endmodule
`default_nettype wire

// ---- logic/twp_top.sv ----
// top: ahb-lite slave with key-gated register write protection
`timescale 1ns/1ps
`default_nettype none
module twp_top
    import twp_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic        hmaster_dbg,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq
);
    twp_wr_if wr ();

    twp_state_t  state_q;
    logic [11:0] aoff_q;
    logic        dbg_q;
    logic [2:0]  prot_mode_q;
    logic        viol_flag_q;
    logic [23:0] viol_src_q;
    logic [NUM_EV-1:0] irq_stat_q;
    logic [NUM_EV-1:0] irq_mask_q;
    logic        sys_opt_q;
    logic [31:0] rd_local_q;
    logic        rd_local_sel_q;
    logic [31:0] store_rdata;

    // address phase decode; hsize is not decoded, every transfer is taken as a whole word
    wire addr_ok  = hsel && hready && htrans[1];
    wire start_wr = addr_ok && hwrite;
    wire start_rd = addr_ok && !hwrite;
    wire in_wr    = (state_q == TWP_WRITE);
    wire in_rd    = (state_q == TWP_READ);

    // write to the protection-mode register and key check
    wire mode_wr  = in_wr && aoff_q == OFF_PROT_MODE;
    wire key_ok   = (hwdata[31:KEY_LSB] == KEY_ACCEPT_VALUE);
    wire mode_upd = mode_wr && key_ok;
    wire key_fail = mode_wr && !key_ok;

    // status read clears the flag unless a debugger reads with the option on
    wire stat_rd  = in_rd && aoff_q == OFF_PROT_STAT;
    wire stat_clr = stat_rd && !(dbg_q && sys_opt_q);

    // write events to the other local registers
    wire istat_wr = in_wr && aoff_q == OFF_IRQ_STAT;
    wire imask_wr = in_wr && aoff_q == OFF_IRQ_MASK;
    wire opt_wr   = in_wr && aoff_q == OFF_SYS_OPT;

    // hand the data phase write to the guard
    assign wr.wr_en   = in_wr;
    assign wr.wr_off  = aoff_q;
    assign wr.wr_data = hwdata;

    twp_guard u_guard (
        .wr    (wr),
        .locks (prot_mode_q)
    );

    twp_ctrl_store u_store (
        .hclk    (hclk),
        .hresetn (hresetn),
        .we      (wr.allow),
        .off     (aoff_q),
        .wdata   (hwdata),
        .roff    (haddr[11:0]),
        .rdata   (store_rdata)
    );

    // events that feed the sticky interrupt status
    wire [NUM_EV-1:0] ev;
    assign ev[EV_VIOL]     = wr.reject;
    assign ev[EV_KEY_FAIL] = key_fail;

    // local read mux, sampled at the address phase so hrdata only selects between flops
    wire local_hit = (haddr[11:0] == OFF_PROT_MODE) || (haddr[11:0] == OFF_PROT_STAT)
                   || (haddr[11:0] == OFF_IRQ_STAT) || (haddr[11:0] == OFF_IRQ_MASK)
                   || (haddr[11:0] == OFF_SYS_OPT);
    wire [31:0] local_rd =
        (haddr[11:0] == OFF_PROT_MODE) ? {29'h0, prot_mode_q} :
        (haddr[11:0] == OFF_PROT_STAT) ? {viol_src_q, 7'h00, viol_flag_q} :
        (haddr[11:0] == OFF_IRQ_STAT)  ? {30'h0, irq_stat_q} :
        (haddr[11:0] == OFF_IRQ_MASK)  ? {30'h0, irq_mask_q} :
        (haddr[11:0] == OFF_SYS_OPT)   ? {31'h0, sys_opt_q} : WORD_RST;

    // bus state machine: one wait-free data phase per transfer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= TWP_IDLE;
            aoff_q  <= 12'h000;
            dbg_q   <= 1'b0;
        end else begin
            if (start_wr)
                state_q <= TWP_WRITE;
            else if (start_rd)
                state_q <= TWP_READ;
            else if (hready)
                state_q <= TWP_IDLE;
            if (addr_ok) begin
                aoff_q <= haddr[11:0];
                dbg_q  <= hmaster_dbg;
            end
        end
    end

    // read data register; a read of the status right after its own
    // update still sees the pre-update value, hazard accepted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_local_q     <= WORD_RST;
            rd_local_sel_q <= 1'b0;
        end else if (start_rd) begin
            rd_local_q     <= local_rd;
            rd_local_sel_q <= local_hit;
        end
    end

    // protection mode lock bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            prot_mode_q <= PROT_MODE_RST;
        else if (mode_upd)
            prot_mode_q <= hwdata[BIT_CTRL_REG:BIT_GENERAL];
    end

    // violation flag and source; a new violation wins over a read clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            viol_flag_q <= 1'b0;
            viol_src_q  <= 24'h000000;
        end else if (wr.reject) begin
            viol_flag_q <= 1'b1;
            viol_src_q  <= {12'h000, aoff_q};
        end else if (stat_clr) begin
            viol_flag_q <= 1'b0;
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_q <= 2'b00;
            irq_mask_q <= 2'b00;
            sys_opt_q  <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(istat_wr ? hwdata[NUM_EV-1:0] : 2'b00)) | ev;
            if (imask_wr)
                irq_mask_q <= hwdata[NUM_EV-1:0];
            if (opt_wr)
                sys_opt_q <= hwdata[0];
        end
    end

    // outputs straight from flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq       <= 1'b0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            irq       <= |(irq_stat_q & irq_mask_q);
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata = rd_local_sel_q ? rd_local_q : store_rdata;
endmodule
`default_nettype wire

// ---- test/twp_properties.sv ----
// checker: bus and protection properties seen at the top ports
`timescale 1ns/1ps
`default_nettype none
module twp_properties
    import twp_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hmaster_dbg,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq
);
    logic [3:0] wr_hist_q;
    wire        wr_acc = hsel & hready & htrans[1] & hwrite;
    // recent writes; irq only moves a few cycles after one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            wr_hist_q <= 4'h0;
        else
            wr_hist_q <= {wr_hist_q[2:0], wr_acc};
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd(logic [11:0] a);
        hsel && hready && htrans[1] && !hwrite && haddr[11:0] == a;
    endsequence
    property p_ready; hreadyout; endproperty
    property p_resp; !hresp; endproperty
    property p_rst_data; $rose(hresetn) |-> hrdata == 32'h0; endproperty
    property p_rst_irq; $rose(hresetn) |-> !irq; endproperty
    property p_key_zero; s_rd(OFF_PROT_MODE) |=> hrdata[31:3] == 29'h0; endproperty
    property p_stat_resv; s_rd(OFF_PROT_STAT) |=> hrdata[7:1] == 7'h0; endproperty
    property p_irq_rise; $rose(irq) |-> wr_hist_q != 4'h0; endproperty
    property p_irq_fall; $fell(irq) |-> wr_hist_q != 4'h0; endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    a_resp: assert property (p_resp) else $error("error response seen");
    a_rst_data: assert property (p_rst_data) else $error("read data not zero");
    a_rst_irq: assert property (p_rst_irq) else $error("irq after reset");
    a_key_zero: assert property (p_key_zero) else $error("key field not zero");
    a_stat_resv: assert property (p_stat_resv) else $error("status gap bits");
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose alone");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
endmodule
bind twp_top twp_properties twp_properties_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hmaster_dbg(hmaster_dbg), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq)
);
`default_nettype wire

// ---- test/testbench.sv ----
// testbench: register-bus tests of the write-protect unit
`timescale 1ns/1ps
`default_nettype none
module testbench
    import twp_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        dbg = 1'b0;
    logic [31:0] hrdata;
    logic [31:0] rd_q;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    int          errors = 0;
    int          checks = 0;
    int          cyc = 0;
    localparam logic [11:0] PROT_OFF [4] = '{OFF_FIFO_MODE, OFF_FIFO_IEN, OFF_FIFO_IDIS, OFF_CTRL};
    twp_top twp_top_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hmaster_dbg(dbg), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq)
    );
    always #25 hclk = ~hclk;
    task automatic print_verdict;
        if (errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // cut a hung handshake short
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors = errors + 1;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks = checks + 1;
        if (s !== e) begin
            errors = errors + 1;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // one single transfer; address held until hready, data until hready again
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic g);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        dbg <= g;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_q = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d, 1'b0);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0, 1'b0);
        chk(rd_q, e);
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(OFF_PROT_MODE, 32'h0);
        rchk(OFF_PROT_STAT, 32'h0);
        wr(OFF_PROT_MODE, 32'h12345607);
        rchk(OFF_PROT_MODE, 32'h0);
        rchk(OFF_IRQ_STAT, 32'h2);
        wr(OFF_IRQ_STAT, 32'h3);
        wr(OFF_FIFO_IEN, 32'h0f);
        wr(OFF_FIFO_MODE, 32'hffffffff);
        wr(OFF_PROT_MODE, {KEY_ACCEPT_VALUE, 8'h07});
        rchk(OFF_PROT_MODE, 32'h7);
        // every lockable register refused, offset recorded, flag cleared by read
        for (int i = 0; i < 4; i++) begin
            wr(PROT_OFF[i], 32'h00ff00ff);
            rchk(OFF_PROT_STAT, {12'h0, PROT_OFF[i], 8'h01});
            rchk(OFF_PROT_STAT, {12'h0, PROT_OFF[i], 8'h00});
        end
        rchk(OFF_FIFO_MODE, FIFO_MODE_MASK);
        rchk(OFF_FIFO_IMASK, 32'h0f);
        chk({31'h0, irq}, 32'h0);
        wr(OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        wr(OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        wr(OFF_PROT_MODE, {KEY_ACCEPT_VALUE - 24'h1, 8'h00});
        rchk(OFF_PROT_MODE, 32'h7);
        wr(OFF_PROT_MODE, {KEY_ACCEPT_VALUE, 8'h00});
        rchk(OFF_PROT_MODE, 32'h0);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_FIFO_IDIS, 32'h0f);
        rchk(OFF_FIFO_IMASK, 32'h0);
        rchk(OFF_PROT_STAT, {12'h0, OFF_CTRL, 8'h00});
        wr(12'h7fc, 32'hffffffff);
        rchk(12'h7fc, 32'h0);
        // debugger reads clear the flag only while the option is off
        wr(OFF_PROT_MODE, {KEY_ACCEPT_VALUE, 8'h04});
        for (int k = 0; k < 2; k++) begin
            wr(OFF_SYS_OPT, 32'(k));
            wr(OFF_CTRL, 32'h0);
            xfer(OFF_PROT_STAT, 1'b0, 32'h0, 1'b1);
            chk(rd_q, {12'h0, OFF_CTRL, 8'h01});
            xfer(OFF_PROT_STAT, 1'b0, 32'h0, 1'b0);
            chk(rd_q & 32'h1, 32'(k));
        end
        // a second reset in mid-run drops all locks
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(OFF_PROT_MODE, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
